// ---- rtl/spc_core.sv ----
`timescale 1ns/1ps
`default_nettype none

// counter core: pure same-clock logic, no synchronisers
module spc_core #(
	parameter int WIDTH = spc_pkg::CNT_WIDTH
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire spc_pkg::spc_ctrl_t ctrl_i,
	output logic [WIDTH-1:0]       count_o,
	output logic                   ripple_carry_out_o,
	output spc_pkg::spc_op_t       op_o
);

	// refuse widths that the four-bit terminal decode cannot serve
	if (WIDTH != spc_pkg::CNT_WIDTH) begin : g_bad_width
		$error("spc_core serves only a 4-bit count");
	end

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;
	wire              count_go;
	wire              at_terminal;

	// clear beats load, load beats counting
	assign count_go = ctrl_i.parallel_count_enable & ctrl_i.trickle_count_enable; // see RL8
	assign op_o = !ctrl_i.sync_clear_n ? spc_pkg::SPC_OP_CLEAR :      // see RL6 see RL7
	              !ctrl_i.load_n       ? spc_pkg::SPC_OP_LOAD  :      // see RL4
	              count_go             ? spc_pkg::SPC_OP_COUNT :
	                                     spc_pkg::SPC_OP_HOLD;        // see RL10

	// next state; the adder wraps 15 to 0 by truncation
	always_comb begin
		unique case (op_o)
			spc_pkg::SPC_OP_CLEAR: count_nxt = spc_pkg::CNT_CLEAR_VAL;       // see RL6
			spc_pkg::SPC_OP_LOAD:  count_nxt = ctrl_i.preset;                // see RL5 see RL16
			spc_pkg::SPC_OP_COUNT: count_nxt = WIDTH'(count_r + 1'b1);       // see RL9
			spc_pkg::SPC_OP_HOLD:  count_nxt = count_r;
		endcase
	end

	// all bits in one register, rising edge only, so no ripple between them
	always_ff @(posedge clk_i) begin // see RL2 see RL3 see RL12
		if (rst_i) begin
			count_r <= spc_pkg::CNT_CLEAR_VAL;
		end else begin
			count_r <= count_nxt;
		end
	end

	// carry follows the trickle enable combinationally so cascades look ahead
	assign at_terminal        = (count_r == spc_pkg::CNT_TERMINAL);
	assign ripple_carry_out_o = ctrl_i.trickle_count_enable & at_terminal; // see RL11
	assign count_o            = count_r; // see RL1

endmodule

`default_nettype wire

// ---- rtl/spc_pkg.sv ----
package spc_pkg;

	// counter geometry and reset values
	localparam int          CNT_WIDTH     = 4;
	localparam logic [3:0]  CNT_CLEAR_VAL = 4'h0;
	localparam logic [3:0]  CNT_TERMINAL  = 4'hF;

	// register map on the wishbone slave, byte addresses compared in full
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_PRESET   = 8'h04;
	localparam logic [7:0]  ADDR_STATUS   = 8'h08;

	// control register fields
	localparam int          CTRL_PAR_EN   = 0;
	localparam int          CTRL_TRK_EN   = 1;
	localparam int          CTRL_CLR_N    = 2;
	localparam int          CTRL_LOAD_N   = 3;
	localparam int          CTRL_SW_MODE  = 4;
	localparam logic [4:0]  CTRL_RESET    = 5'h0C;

	// status register fields
	localparam int          STAT_CARRY    = 4;

	// operation chosen at a clock edge
	typedef enum logic [1:0] {
		SPC_OP_HOLD,
		SPC_OP_COUNT,
		SPC_OP_LOAD,
		SPC_OP_CLEAR
	} spc_op_t;

	// control levels grouped as they travel to the counter core
	typedef struct packed {
		logic       sync_clear_n;
		logic       load_n;
		logic       parallel_count_enable;
		logic       trickle_count_enable;
		logic [3:0] preset;
	} spc_ctrl_t;

endpackage

// ---- rtl/spc_top.sv ----
// Summary of operation
// RL1 - four-bit count held, shown on outputs
// RL2 - state updates on rising clock edge only
// RL3 - all count bits change together
// RL4 - load low suppresses counting at edge
// RL5 - load copies preset bits into count
// RL6 - clear low forces count to zero
// RL7 - clear wins over load
// RL8 - count up when both enables high
// RL9 - fifteen wraps to zero
// RL10 - either enable low holds the count
// RL11 - carry high with trickle enable at fifteen; the trickle pin here reaches the carry at the second edge
// RL12 - control changes act only at next edge; pins here reach the count at the third edge
// RL13 - enables may change any time, edge samples
// RL14 - cascade next stage from ripple carry
// RL15 - decode a count to clear for shorter cycle
// RL16 - bit zero least significant, preset same order
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module spc_top #(
	parameter int WIDTH = spc_pkg::CNT_WIDTH
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// counter pins, from outside the clock domain
	input  wire logic              sync_clear_n_i,
	input  wire logic              load_n_i,
	input  wire logic              parallel_count_enable_i,
	input  wire logic              trickle_count_enable_i,
	input  wire logic [WIDTH-1:0]  preset_i,
	output logic      [WIDTH-1:0]  count_o,
	output logic                   ripple_carry_out_o,
	// classic wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o
);

	// refuse widths that the register fields cannot serve
	if (WIDTH != spc_pkg::CNT_WIDTH) begin : g_bad_width
		$error("spc_top serves only a 4-bit count");
	end

	// two-flop synchronisers on all pin inputs; first stage feeds only the second
	localparam int PIN_W = 4 + WIDTH;
	logic [PIN_W-1:0] pin_meta_r;
	logic [PIN_W-1:0] pin_sync_r;
	wire  [PIN_W-1:0] pin_raw;

	assign pin_raw = {sync_clear_n_i, load_n_i, parallel_count_enable_i,
	                  trickle_count_enable_i, preset_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_r <= {2'h3, 2'h0, {WIDTH{1'b0}}};
			pin_sync_r <= {2'h3, 2'h0, {WIDTH{1'b0}}};
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
		end
	end

	// software control and preset registers
	logic [4:0]       ctrl_r;
	logic [WIDTH-1:0] preset_r;
	logic             ack_r;
	logic [31:0]      rdat_r;

	// wishbone decode; the byte lane 0 carries every writable bit
	wire wb_req     = wb_cyc_i & wb_stb_i & ~ack_r;
	wire hit_ctrl   = (wb_adr_i == spc_pkg::ADDR_CTRL);
	wire hit_preset = (wb_adr_i == spc_pkg::ADDR_PRESET);
	wire hit_status = (wb_adr_i == spc_pkg::ADDR_STATUS);
	wire wr_lane0   = wb_req & wb_we_i & wb_sel_i[0];
	wire wr_ctrl    = wr_lane0 & hit_ctrl;
	wire wr_preset  = wr_lane0 & hit_preset;

	// a software-mode bit chooses register control over the pins
	wire sw_mode = ctrl_r[spc_pkg::CTRL_SW_MODE];
	spc_pkg::spc_ctrl_t ctrl_sel;
	assign ctrl_sel.sync_clear_n = sw_mode ? ctrl_r[spc_pkg::CTRL_CLR_N]
	                                       : pin_sync_r[WIDTH+3];
	assign ctrl_sel.load_n = sw_mode ? ctrl_r[spc_pkg::CTRL_LOAD_N]
	                                 : pin_sync_r[WIDTH+2];
	assign ctrl_sel.parallel_count_enable = sw_mode ? ctrl_r[spc_pkg::CTRL_PAR_EN]
	                                                : pin_sync_r[WIDTH+1]; // see RL13
	assign ctrl_sel.trickle_count_enable = sw_mode ? ctrl_r[spc_pkg::CTRL_TRK_EN]
	                                               : pin_sync_r[WIDTH];    // see RL13
	assign ctrl_sel.preset = sw_mode ? preset_r : pin_sync_r[WIDTH-1:0];

	spc_pkg::spc_op_t core_op;
	logic [WIDTH-1:0] core_count;
	logic             core_carry;

	spc_core #(
		.WIDTH (WIDTH)
	) u_core (
		.clk_i              (clk_i),
		.rst_i              (rst_i),
		.ctrl_i             (ctrl_sel),
		.count_o            (core_count),
		.ripple_carry_out_o (core_carry),
		.op_o               (core_op)
	);

	assign count_o            = core_count;
	assign ripple_carry_out_o = core_carry; // see RL14 see RL15

	// read mux: status shows count, carry and the pending operation
	wire [31:0] status_word = {25'h0, core_op, core_carry, core_count};
	wire [31:0] rd_mux = hit_ctrl   ? {27'h0, ctrl_r} :
	                     hit_preset ? {28'h0, preset_r} :
	                     hit_status ? status_word : 32'h0;

	// register writes and a one-cycle ack; read data stands until the next access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r   <= spc_pkg::CTRL_RESET;
			preset_r <= spc_pkg::CNT_CLEAR_VAL;
			ack_r    <= 1'b0;
			rdat_r   <= 32'h0;
		end else begin
			ack_r  <= wb_req;
			if (wb_req) rdat_r <= rd_mux;
			if (wr_ctrl) ctrl_r <= wb_dat_i[4:0];
			if (wr_preset) preset_r <= wb_dat_i[WIDTH-1:0];
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

endmodule

`default_nettype wire

// ---- testbench/spc_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// surrounding control logic plus one cascaded upper counter stage
module spc_ctl_model (
	input wire logic	clk_i,
	input wire logic	rst_i,
	input wire spc_pkg::spc_ctrl_t	req_i,
	input wire logic	carry_i,
	input wire logic [3:0]	count_i,
	input wire logic	short_i,
	output spc_pkg::spc_ctrl_t	pins_o,
	output logic [3:0]	hi_o
);
	// decoded stop count; the pin synchroniser lets the count run on before clear acts
	localparam logic [3:0] STOP_CNT = 4'hB;
	wire	stop_hit = short_i && (count_i == STOP_CNT);
	// levels move freely; the decoder pulls clear, the top bit of the group, low
	assign pins_o = req_i & {~stop_hit, 7'h7F};
	// upper stage advances only while the lower stage offers its carry
	always_ff @(posedge clk_i) hi_o <= rst_i ? 4'h0 : hi_o + {3'h0, carry_i};
endmodule
`default_nettype wire

// ---- testbench/spc_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// pin levels reach the count three edges late, so count checks look back three cycles, the carry check two
module spc_top_chk #(parameter int WIDTH = 4) (
	input wire logic	clk_i,
	input wire logic	rst_i,
	input wire logic	sync_clear_n_i,
	input wire logic	load_n_i,
	input wire logic	parallel_count_enable_i,
	input wire logic	trickle_count_enable_i,
	input wire logic [WIDTH-1:0]	preset_i,
	input wire logic [WIDTH-1:0]	count_o,
	input wire logic	ripple_carry_out_o,
	input wire logic	wb_cyc_i,
	input wire logic	wb_stb_i,
	input wire logic	wb_we_i,
	input wire logic [7:0]	wb_adr_i,
	input wire logic [3:0]	wb_sel_i,
	input wire logic [31:0]	wb_dat_i,
	input wire logic [31:0]	wb_dat_o,
	input wire logic	wb_ack_o
);
	logic [3:0]	sw_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// software mode history; pin checks wait until it has been off for four edges
	wire	wr = wb_ack_o && wb_we_i && wb_adr_i == spc_pkg::ADDR_CTRL && wb_sel_i[0];
	wire	sw_nxt = wr ? wb_dat_i[spc_pkg::CTRL_SW_MODE] : sw_r[0];
	wire	pm = (sw_r == 4'h0);
	wire	go = sync_clear_n_i && load_n_i;
	wire	up = go && parallel_count_enable_i && trickle_count_enable_i;
	always_ff @(posedge clk_i) sw_r <= rst_i ? 4'h0 : {sw_r[2:0], sw_nxt};
	clr_zero_a:
	assert property (pm && !$past(sync_clear_n_i, 3) |-> count_o == 4'h0) else $error("no clear");
	load_copy_a:
	assert property (pm && $past(sync_clear_n_i, 3) && !$past(load_n_i, 3)
		|-> count_o == $past(preset_i, 3)) else $error("bad load");
	count_up_a:
	assert property (pm && $past(up, 3) |-> count_o == $past(count_o) + 4'h1) else $error("no step");
	count_hold_a:
	assert property (pm && $past(go, 3) && !$past(up, 3) |-> $stable(count_o)) else $error("drift");
	carry_level_a:
	assert property (pm |-> ripple_carry_out_o == (count_o == 4'hF && $past(trickle_count_enable_i, 2)))
		else $error("bad carry");
	ack_pulse_a:
	assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	ack_answer_a:
	assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("late ack");
	ack_cause_a:
	assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("stray ack");
	cover property (pm && $past(up, 3) && count_o == 4'h0);
	cover property ($rose(ripple_carry_out_o));
	cover property (wb_ack_o && !wb_we_i);
endmodule
`default_nettype wire

// ---- testbench/tb_spc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_spc_top;
	logic	clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, carry, short_dec;
	logic [7:0]	wb_adr_i;
	logic [3:0]	wb_sel_i, count, hi;
	logic [31:0]	wb_dat_i, wb_dat_o, rd;
	spc_pkg::spc_ctrl_t	req, pins;
	int	miscompares = 0, n_tests = 0;
	spc_top uut (.clk_i, .rst_i, .sync_clear_n_i(pins.sync_clear_n), .load_n_i(pins.load_n),
		.parallel_count_enable_i(pins.parallel_count_enable), .preset_i(pins.preset),
		.trickle_count_enable_i(pins.trickle_count_enable), .count_o(count),
		.ripple_carry_out_o(carry), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o);
	spc_ctl_model ctl (.clk_i, .rst_i, .req_i(req), .carry_i(carry), .count_i(count),
		.short_i(short_dec), .pins_o(pins), .hi_o(hi));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one classic cycle; held until ack is seen at an edge, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge clk_i);
	endtask
	// bits: clear_n, load_n, parallel, trickle, preset[3:0]
	task automatic pin(input logic [7:0] v, input int n);
		req <= v;
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wrap_up;
		$display("mismatches %0d of %0d checks", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// the whole sequence needs just over a hundred cycles
	initial begin
		#100000;
		miscompares++;
		wrap_up;
	end
	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 43'h0;
		wb_sel_i = 4'hF;
		req = 8'hC0;
		short_dec = 1'b0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0C);
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h00);
		pin(8'hBC, 1);
		pin(8'hC0, 5);
		chk(count, 32'hC);
		pin(8'h0C, 1);
		pin(8'hC0, 5);
		chk(count, 32'h0);
		pin(8'hBC, 1);
		pin(8'hF0, 6);
		pin(8'hC0, 5);
		chk(count, 32'h2);
		chk(hi, 32'h1);
		pin(8'hE0, 5);
		chk(count, 32'h2);
		pin(8'hBF, 1);
		pin(8'hD0, 5);
		chk(carry, 32'h1);
		pin(8'hE0, 5);
		chk(carry, 32'h0);
		chk(count, 32'hF);
		pin(8'h40, 1);
		pin(8'hC0, 5);
		chk(count, 32'h0);
		// shortened cycle: load the stop count, the decoder then clears it
		short_dec <= 1'b1;
		pin(8'hBB, 1);
		pin(8'hC0, 3);
		chk(count, 32'hB);
		pin(8'hC0, 5);
		chk(count, 32'h0);
		short_dec <= 1'b0;
		wb(1'b1, 8'h04, 32'h5);
		wb(1'b1, 8'h00, 32'h14);
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h45);
		wb(1'b1, 8'h00, 32'h1C);
		wb(1'b1, 8'h08, 32'hFF);
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h05);
		wb(1'b0, 8'hFC, 32'h0);
		chk(rd, 32'h0);
		// software clear, then three counting edges between two control writes
		wb(1'b1, 8'h00, 32'h1B);
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h60);
		wb(1'b1, 8'h00, 32'h1F);
		wb(1'b1, 8'h00, 32'h1C);
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h03);
		wb(1'b1, 8'h00, 32'h0C);
		wrap_up;
	end
endmodule
bind spc_top spc_top_chk #(.WIDTH(WIDTH)) chk_i (.*);
`default_nettype wire
